/* File: rtl/cmcr_params.svh */
// Constants for the compare and condition-bit logic unit
`ifndef CMCR_PARAMS_SVH
`define CMCR_PARAMS_SVH

// ----------------------------------------------------------------
// Primary opcodes, instruction word bits 31:26
// ----------------------------------------------------------------
`define CMCR_PRI_EXT        6'h1F
`define CMCR_PRI_CMP_IMM_S  6'h0B
`define CMCR_PRI_CMP_IMM_U  6'h0A
`define CMCR_PRI_COND       6'h13

// ----------------------------------------------------------------
// Extended opcodes, instruction word bits 10:1
// ----------------------------------------------------------------
`define CMCR_XO_CMP_S       10'h000
`define CMCR_XO_CMP_U       10'h020
`define CMCR_XO_CLZ         10'h01A
`define CMCR_XO_AND         10'h101
`define CMCR_XO_ANDC        10'h081
`define CMCR_XO_EQV         10'h121
`define CMCR_XO_NAND        10'h0E1

// ----------------------------------------------------------------
// Compare result codes (less, greater, same)
// ----------------------------------------------------------------
`define CMCR_CODE_LESS      3'h4
`define CMCR_CODE_GREATER   3'h2
`define CMCR_CODE_SAME      3'h1

// ----------------------------------------------------------------
// Register port offsets and reset values
// ----------------------------------------------------------------
`define CMCR_OFS_COND       4'h0
`define CMCR_OFS_CTRL       4'h4
`define CMCR_OFS_STATUS     4'h8
`define CMCR_RST_COND       32'h0000_0000
`define CMCR_RST_ENABLE     1'h1
`define CMCR_COUNT_MAX      16'hFFFF

`endif

/* File: rtl/cmcr_pkg.sv */
// Types shared by the compare and condition-bit logic unit
package cmcr_pkg;

    // Decoded operation
    typedef enum logic [3:0] {
        OP_NONE, OP_CMP_REG_S, OP_CMP_IMM_S, OP_CMP_REG_U, OP_CMP_IMM_U,
        OP_CLZ, OP_BIT_AND, OP_BIT_ANDC, OP_BIT_EQV, OP_BIT_NAND, OP_INVALID
    } cmcr_op_e;

    // Instruction issue with its operand values
    typedef struct packed {
        logic        valid;
        logic [31:0] word;
        logic [31:0] source_reg_a;
        logic [31:0] second_source_reg;
    } cmcr_issue_s;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } cmcr_bus_s;

    // General register write-back
    typedef struct packed {
        logic        wr;
        logic [4:0]  idx;
        logic [31:0] data;
    } cmcr_gpr_s;

    // Whole state of the unit
    typedef struct packed {
        logic [31:0] condition_bits;
        logic        enable;
        logic [15:0] invalid_count;
        cmcr_gpr_s   gpr;
        logic        illegal;
        logic [31:0] rd_data;
    } cmcr_state_s;

endpackage : cmcr_pkg

/* File: rtl/cmcr_unit.sv */
// Compare, leading-zero count and condition-bit logic datapath slice
//
// Notes on behaviour
// - Decode four compare encodings to compare path
// - Register compare treats operands as signed
// - Signed immediate is sign-extended, signed compare
// - Logical register compare treats operands unsigned
// - Unsigned immediate is zero-extended, unsigned compare
// - Code 100/010/001 written to target field
// - Field fourth bit copies summary overflow
// - Width bit set means invalid form
// - Count leading zeros from the most significant bit
// - Count ranges 0 to 32, zero word gives 32
// - Record bit updates first field, less cleared
// - Bit AND of two condition bits
// - Bit AND with complement of second
// - Bit equivalence, inverted exclusive OR
// - Bit NAND of two condition bits
// - Bit logic alters only destination bit
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "cmcr_params.svh"

module cmcr_unit
    import cmcr_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    // Instruction issue and summary overflow from the exception register
    input  wire cmcr_issue_s i_issue,
    input  wire logic        i_summary_overflow,
    // Register port
    input  wire cmcr_bus_s   i_bus,
    output cmcr_gpr_s        o_gpr,
    output logic [31:0]      o_condition_bits,
    output logic             o_illegal,
    output logic [31:0]      o_rd_data
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Three-bit compare code, signed or unsigned
    function automatic logic [2:0] cmp_code(input logic [31:0] a, input logic [31:0] b,
                                            input logic sgn);
        logic lt;
        lt = sgn ? ($signed(a) < $signed(b)) : (a < b);
        if (lt) begin
            return `CMCR_CODE_LESS;
        end else if (a == b) begin
            return `CMCR_CODE_SAME;
        end
        return `CMCR_CODE_GREATER;
    endfunction : cmp_code

    // Leading zeros counted from the most significant bit
    function automatic logic [5:0] count_zeros(input logic [31:0] w);
        logic [5:0] n;
        logic       hit;
        n   = 6'h00;
        hit = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (!hit) begin
                if (w[i]) begin
                    hit = 1'b1;
                end else begin
                    n = n + 6'h01;
                end
            end
        end
        return n;
    endfunction : count_zeros

    // Four-bit field f, field 0 in the top nibble
    function automatic logic [3:0] field_get(input logic [31:0] c, input logic [2:0] f);
        logic [4:0] lsb;
        lsb = {3'h7 - f, 2'b00};
        return c[lsb +: 4];
    endfunction : field_get

    function automatic logic [31:0] field_put(input logic [31:0] c, input logic [2:0] f,
                                              input logic [3:0] v);
        logic [31:0] r;
        logic [4:0]  lsb;
        r   = c;
        lsb = {3'h7 - f, 2'b00};
        r[lsb +: 4] = v;
        return r;
    endfunction : field_put

    // Single condition bit, index 0 is the most significant bit
    function automatic logic bit_get(input logic [31:0] c, input logic [4:0] idx);
        return c[5'h1F - idx];
    endfunction : bit_get

    // ----------------------------------------------------------------
    // State and instruction fields
    // ----------------------------------------------------------------
    cmcr_state_s st;                   // Registered state
    cmcr_state_s next_st;              // Next state
    cmcr_op_e    op;                   // Decoded operation
    logic        exec_go;              // Instruction accepted this cycle
    logic [2:0]  compare_target_field; // Target field of a compare
    logic        width_bit;            // Sixty-four bit request flag
    logic        record_bit;           // Record into first field
    logic [4:0]  dest_gpr;             // Count destination register
    logic [4:0]  cond_dest_index;      // Destination condition bit
    logic [4:0]  cond_src_index_a;     // First source condition bit
    logic [4:0]  cond_src_index_b;     // Second source condition bit
    logic [31:0] signed_immediate;     // Sign-extended immediate
    logic [31:0] unsigned_immediate;   // Zero-extended immediate
    logic        src_a_bit;            // Value of first source bit
    logic        src_b_bit;            // Value of second source bit
    logic        bus_cond_wr;          // Software write to condition bits

    // ----------------------------------------------------------------
    // Instruction decode
    // ----------------------------------------------------------------

    // Field extraction and operation decode
    always_comb begin
        compare_target_field = i_issue.word[25:23];
        width_bit            = i_issue.word[21];
        record_bit           = i_issue.word[0];
        dest_gpr             = i_issue.word[20:16];
        cond_dest_index      = i_issue.word[25:21];
        cond_src_index_a     = i_issue.word[20:16];
        cond_src_index_b     = i_issue.word[15:11];
        signed_immediate     = {{16{i_issue.word[15]}}, i_issue.word[15:0]};
        unsigned_immediate   = {16'h0000, i_issue.word[15:0]};
        src_a_bit            = bit_get(st.condition_bits, cond_src_index_a);
        src_b_bit            = bit_get(st.condition_bits, cond_src_index_b);
        exec_go              = i_issue.valid && st.enable;
        bus_cond_wr          = i_bus.wr && (i_bus.addr == `CMCR_OFS_COND);
        op                   = OP_NONE;
        // Compare encodings, width bit set is refused
        unique case (i_issue.word[31:26])
            `CMCR_PRI_CMP_IMM_S: begin
                op = width_bit ? OP_INVALID : OP_CMP_IMM_S;
            end
            `CMCR_PRI_CMP_IMM_U: begin
                op = width_bit ? OP_INVALID : OP_CMP_IMM_U;
            end
            `CMCR_PRI_EXT: begin
                if (i_issue.word[10:1] == `CMCR_XO_CMP_S) begin
                    op = width_bit ? OP_INVALID : OP_CMP_REG_S;
                end else if (i_issue.word[10:1] == `CMCR_XO_CMP_U) begin
                    op = width_bit ? OP_INVALID : OP_CMP_REG_U;
                end else if (i_issue.word[10:1] == `CMCR_XO_CLZ) begin
                    op = OP_CLZ;
                end
            end
            `CMCR_PRI_COND: begin
                if (i_issue.word[10:1] == `CMCR_XO_AND) begin
                    op = OP_BIT_AND;
                end else if (i_issue.word[10:1] == `CMCR_XO_ANDC) begin
                    op = OP_BIT_ANDC;
                end else if (i_issue.word[10:1] == `CMCR_XO_EQV) begin
                    op = OP_BIT_EQV;
                end else if (i_issue.word[10:1] == `CMCR_XO_NAND) begin
                    op = OP_BIT_NAND;
                end
            end
            // Other opcodes belong to other units
            default: begin
                op = OP_NONE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    // Register port first, then the instruction on top of it
    always_comb begin
        logic [2:0]  code;
        logic [5:0]  zeros;
        logic        bit_val;
        logic [31:0] cond_tmp;
        code     = 3'h0;
        zeros    = 6'h00;
        bit_val  = 1'b0;
        cond_tmp = 32'h0000_0000;
        next_st         = st;
        next_st.gpr.wr  = 1'b0;
        next_st.illegal = 1'b0;
        next_st.rd_data = 32'h0000_0000;
        // Software writes
        if (i_bus.wr) begin
            if (i_bus.addr == `CMCR_OFS_COND) begin
                next_st.condition_bits = i_bus.wdata;
            end else if (i_bus.addr == `CMCR_OFS_CTRL) begin
                next_st.enable = i_bus.wdata[0];
            end
        end
        // Software reads, unmapped offsets read zero
        if (i_bus.rd) begin
            if (i_bus.addr == `CMCR_OFS_COND) begin
                next_st.rd_data = st.condition_bits;
            end else if (i_bus.addr == `CMCR_OFS_CTRL) begin
                next_st.rd_data = {31'h0000_0000, st.enable};
            end else if (i_bus.addr == `CMCR_OFS_STATUS) begin
                next_st.rd_data = {16'h0000, st.invalid_count};
            end
        end
        // Instruction execution; sources come from the registered bits
        if (exec_go) begin
            unique case (op)
                OP_CMP_REG_S, OP_CMP_IMM_S, OP_CMP_REG_U, OP_CMP_IMM_U: begin
                    if (op == OP_CMP_REG_S) begin
                        code = cmp_code(i_issue.source_reg_a, i_issue.second_source_reg,
                                        1'b1);
                    end else if (op == OP_CMP_IMM_S) begin
                        code = cmp_code(i_issue.source_reg_a, signed_immediate, 1'b1);
                    end else if (op == OP_CMP_REG_U) begin
                        code = cmp_code(i_issue.source_reg_a, i_issue.second_source_reg,
                                        1'b0);
                    end else begin
                        code = cmp_code(i_issue.source_reg_a, unsigned_immediate, 1'b0);
                    end
                    // Code and summary overflow into the target field
                    next_st.condition_bits = field_put(next_st.condition_bits,
                        compare_target_field, {code, i_summary_overflow});
                end
                OP_CLZ: begin
                    zeros            = count_zeros(i_issue.source_reg_a);
                    next_st.gpr.wr   = 1'b1;
                    next_st.gpr.idx  = dest_gpr;
                    next_st.gpr.data = {26'h000_0000, zeros};
                    // Record form: less clear, greater if nonzero, same if zero
                    if (record_bit) begin
                        next_st.condition_bits = field_put(next_st.condition_bits, 3'h0,
                            {1'b0, zeros != 6'h00, zeros == 6'h00,
                             i_summary_overflow});
                    end
                end
                OP_BIT_AND, OP_BIT_ANDC, OP_BIT_EQV, OP_BIT_NAND: begin
                    if (op == OP_BIT_AND) begin
                        bit_val = src_a_bit & src_b_bit;
                    end else if (op == OP_BIT_ANDC) begin
                        bit_val = src_a_bit & ~src_b_bit;
                    end else if (op == OP_BIT_EQV) begin
                        bit_val = ~(src_a_bit ^ src_b_bit);
                    end else begin
                        bit_val = ~(src_a_bit & src_b_bit);
                    end
                    // Only the destination bit changes; sources were read first
                    cond_tmp = next_st.condition_bits;
                    cond_tmp[5'h1F - cond_dest_index] = bit_val;
                    next_st.condition_bits = cond_tmp;
                end
                OP_INVALID: begin
                    next_st.illegal = 1'b1;
                    if (st.invalid_count != `CMCR_COUNT_MAX) begin
                        next_st.invalid_count = st.invalid_count + 16'h0001;
                    end
                end
                OP_NONE: begin
                    next_st.illegal = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    // Whole state in one flop bank
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st                <= '0;
            st.condition_bits <= `CMCR_RST_COND;
            st.enable         <= `CMCR_RST_ENABLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign o_gpr            = st.gpr;
    assign o_condition_bits = st.condition_bits;
    assign o_illegal        = st.illegal;
    assign o_rd_data        = st.rd_data;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    decode_cmp_a: assert property ((exec_go && op inside {OP_CMP_REG_S, OP_CMP_REG_U,
        OP_CMP_IMM_S, OP_CMP_IMM_U}) |=> !o_illegal && !o_gpr.wr)
        else $error("compare decoded wrongly");
    signed_reg_a: assert property ((exec_go && op == OP_CMP_REG_S && !bus_cond_wr) |=>
        field_get(o_condition_bits, $past(compare_target_field)) ==
        {cmp_code($past(i_issue.source_reg_a), $past(i_issue.second_source_reg), 1'b1),
         $past(i_summary_overflow)})
        else $error("signed register compare wrong");
    signed_imm_a: assert property ((exec_go && op == OP_CMP_IMM_S && !bus_cond_wr) |=>
        field_get(o_condition_bits, $past(compare_target_field)) ==
        {cmp_code($past(i_issue.source_reg_a), $past(signed_immediate), 1'b1),
         $past(i_summary_overflow)})
        else $error("signed immediate compare wrong");
    unsigned_reg_a: assert property ((exec_go && op == OP_CMP_REG_U && !bus_cond_wr) |=>
        field_get(o_condition_bits, $past(compare_target_field)) ==
        {cmp_code($past(i_issue.source_reg_a), $past(i_issue.second_source_reg), 1'b0),
         $past(i_summary_overflow)})
        else $error("unsigned register compare wrong");
    unsigned_imm_a: assert property ((exec_go && op == OP_CMP_IMM_U && !bus_cond_wr) |=>
        field_get(o_condition_bits, $past(compare_target_field)) ==
        {cmp_code($past(i_issue.source_reg_a), {16'h0000, $past(i_issue.word[15:0])}, 1'b0),
         $past(i_summary_overflow)})
        else $error("unsigned immediate compare wrong");
    summary_copy_a: assert property ((exec_go && op == OP_CMP_IMM_U && !bus_cond_wr) |=>
        bit_get(o_condition_bits, {$past(compare_target_field), 2'b11}) ==
        $past(i_summary_overflow))
        else $error("summary overflow not copied");
    invalid_form_a: assert property ((exec_go && op == OP_INVALID && !bus_cond_wr) |=>
        o_illegal && $stable(o_condition_bits) && !o_gpr.wr)
        else $error("invalid form not refused");
    lead_zero_a: assert property ((exec_go && op == OP_CLZ) |=> o_gpr.wr &&
        o_gpr.idx == $past(dest_gpr) &&
        o_gpr.data == {26'h000_0000, count_zeros($past(i_issue.source_reg_a))})
        else $error("leading zero count wrong");
    zero_word_a: assert property ((exec_go && op == OP_CLZ && i_issue.source_reg_a == 32'h0)
        |=> o_gpr.data == 32'h0000_0020)
        else $error("zero word count not 32");
    record_field_a: assert property ((exec_go && op == OP_CLZ && record_bit && !bus_cond_wr)
        |=> !o_condition_bits[31] && (o_condition_bits[29] == (o_gpr.data == 32'h0)))
        else $error("record field wrong");
    bit_logic_a: assert property ((exec_go && op == OP_BIT_NAND && !bus_cond_wr) |=>
        bit_get(o_condition_bits, $past(cond_dest_index)) ==
        !($past(src_a_bit) && $past(src_b_bit)))
        else $error("bit nand wrong");
    bit_only_a: assert property ((exec_go && op inside {OP_BIT_AND, OP_BIT_ANDC,
        OP_BIT_EQV, OP_BIT_NAND} && !bus_cond_wr) |=>
        $countones(o_condition_bits ^ $past(st.condition_bits)) <= 1)
        else $error("bit logic touched other bits");

    cmp_seen_c:   cover property (exec_go && op == OP_CMP_REG_S ##1 exec_go && op == OP_CLZ);
    clz_zero_c:   cover property (exec_go && op == OP_CLZ && i_issue.source_reg_a == 32'h0);
    bit_same_c:   cover property (exec_go && op == OP_BIT_EQV &&
                                  cond_dest_index == cond_src_index_a);
    invalid_c:    cover property (exec_go && op == OP_INVALID);

endmodule : cmcr_unit

/* File: dv/tb_top.sv */
// Self-checking testbench for the compare and condition-bit logic unit
`timescale 1ns/1ps
`include "cmcr_params.svh"

module tb_top;
    import cmcr_pkg::*;

    // ------------------------------------------------------------
    // Signals and expected state
    // ------------------------------------------------------------
    logic        i_mclk;              // Core clock
    logic        i_rstn;              // Reset, active low
    cmcr_issue_s i_issue;             // Instruction issue
    logic        i_summary_overflow;  // Summary overflow input
    cmcr_bus_s   i_bus;               // Register port request
    cmcr_gpr_s   o_gpr;               // Count write-back
    logic [31:0] o_condition_bits;    // Condition register
    logic        o_illegal;           // Invalid form pulse
    logic [31:0] o_rd_data;           // Read data
    logic [31:0] cr;                  // Expected condition bits
    int          n_errors = 0;        // Mismatch count
    int          checks = 0;          // Comparison count

    cmcr_unit uut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_issue(i_issue),
        .i_summary_overflow(i_summary_overflow), .i_bus(i_bus), .o_gpr(o_gpr),
        .o_condition_bits(o_condition_bits), .o_illegal(o_illegal), .o_rd_data(o_rd_data));

    // ------------------------------------------------------------
    // Clock, checking and closing
    // ------------------------------------------------------------
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    // Compare one value and count it
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Print counts and verdict, then stop
    task automatic report_and_stop;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Bus and issue drivers
    // ------------------------------------------------------------
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_mclk);
        i_bus <= '0;
    endtask : bus_wr

    // Read, check data in the next cycle, then that it returns to zero
    task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge i_mclk);
        i_bus <= '0;
        #1 chk(o_rd_data, exp);
        @(posedge i_mclk);
        #1 chk(o_rd_data, 32'h0000_0000);
    endtask : bus_rd

    // Issue one instruction and check the answer cycle
    task automatic run(input logic [31:0] w, a, b, input logic so, ill, gw);
        @(posedge i_mclk);
        i_issue <= '{valid: 1'b1, word: w, source_reg_a: a, second_source_reg: b};
        i_summary_overflow <= so;
        @(posedge i_mclk);
        i_issue.valid <= 1'b0;
        #1 chk(o_illegal, ill);
        chk(o_gpr.wr, gw);
        chk(o_condition_bits, cr);
    endtask : run

    // Compare kinds: 0 reg signed, 1 imm signed, 2 reg unsigned, 3 imm unsigned
    task automatic cmp(input int k, input int f, input logic [31:0] a, b, input logic so);
        logic [31:0] base [4];
        logic [31:0] bx;
        logic        lt;
        base = '{32'h7C00_0000, 32'h2C00_0000, 32'h7C00_0040, 32'h2800_0000};
        bx = (k == 1) ? {{16{b[15]}}, b[15:0]} : (k == 3) ? {16'h0000, b[15:0]} : b;
        lt = (k < 2) ? ($signed(a) < $signed(bx)) : (a < bx);
        cr[31-4*f -: 4] = {lt ? 3'h4 : (a == bx) ? 3'h1 : 3'h2, so};
        run(base[k] | (f << 23) | 32'h0003_0000 | (k[0] ? b & 32'h0000_FFFF : 32'h0000_2000),
            a, b, so, 1'b0, 1'b0);
    endtask : cmp

    // Leading zero count to register 9, with expected count n
    task automatic clz(input logic [31:0] s, input logic rc, so, input logic [5:0] n);
        if (rc) cr[31:28] = {1'b0, n != 0, n == 0, so};
        run(32'h7C00_0034 | 32'h00E9_0000 | rc, s, 32'h0000_0000, so, 1'b0, 1'b1);
        chk(o_gpr.idx, 5'h09);
        chk(o_gpr.data, n);
    endtask : clz

    // Condition bit op: 0 and, 1 and-complement, 2 equivalence, 3 nand
    task automatic bop(input int op, input logic [4:0] d, a, b);
        logic [31:0] base [4];
        logic        x;
        logic        y;
        base = '{32'h4C00_0202, 32'h4C00_0102, 32'h4C00_0242, 32'h4C00_01C2};
        x = cr[31-a];
        y = cr[31-b];
        case (op)
            0: cr[31-d] = x & y;
            1: cr[31-d] = x & ~y;
            2: cr[31-d] = ~(x ^ y);
            default: cr[31-d] = ~(x & y);
        endcase
        run(base[op] | {6'h00, d, a, b, 11'h000}, 0, 0, 1'b0, 1'b0, 1'b0);
    endtask : bop

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk(o_condition_bits | o_rd_data | o_gpr.wr | o_illegal, 32'h0000_0000);
        i_rstn <= 1'b1;
        bus_rd(4'h4, 32'h0000_0001);
        bus_rd(4'h8, 32'h0000_0000);
        bus_rd(4'hC, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_compare;
        cr = 32'hA5C3_0F69;
        bus_wr(4'h0, cr);
        cmp(0, 0, 32'h8000_0000, 32'h0000_0001, 1'b0);
        cmp(2, 7, 32'h8000_0000, 32'h0000_0001, 1'b1);
        cmp(1, 3, 32'hFFFF_FFFF, 32'h0000_FFFF, 1'b0);
        cmp(3, 5, 32'h0000_FFFF, 32'h0000_FFFF, 1'b1);
        cmp(1, 1, 32'h0000_0000, 32'h0000_8000, 1'b0);
        cmp(3, 6, 32'h0000_0000, 32'h0000_8000, 1'b0);
        cmp(0, 2, 32'h0000_0005, 32'h0000_0005, 1'b1);
        cmp(2, 4, 32'h0000_0003, 32'h0000_0009, 1'b0);
        $display("test compare done");
    endtask : t_compare

    task automatic t_width;
        run(32'h7C20_0000 | 32'h0003_2000, 1, 2, 1'b0, 1'b1, 1'b0);
        run(32'h2C20_0005, 1, 0, 1'b1, 1'b1, 1'b0);
        bus_rd(4'h8, 32'h0000_0002);
        $display("test width done");
    endtask : t_width

    task automatic t_clz;
        clz(32'h0000_0000, 1'b1, 1'b0, 6'd32);
        clz(32'h8000_0000, 1'b1, 1'b1, 6'd0);
        clz(32'h0001_0000, 1'b0, 1'b1, 6'd15);
        clz(32'h0000_0001, 1'b1, 1'b0, 6'd31);
        $display("test clz done");
    endtask : t_clz

    task automatic t_bits;
        cr = 32'h0000_FFFF;
        bus_wr(4'h0, cr);
        for (int op = 0; op < 4; op++) begin
            for (int ab = 0; ab < 4; ab++) begin
                bop(op, 5'(4 + op * 4 + ab), ab[1] ? 5'd20 : 5'd2, ab[0] ? 5'd21 : 5'd3);
            end
        end
        bop(3, 5'd25, 5'd25, 5'd25);
        bop(2, 5'd25, 5'd25, 5'd26);
        $display("test bits done");
    endtask : t_bits

    task automatic t_enable;
        bus_wr(4'h4, 32'h0000_0000);
        bus_rd(4'h4, 32'h0000_0000);
        run(32'h7C00_0000 | 32'h0003_2000, 1, 2, 1'b1, 1'b0, 1'b0);
        bus_wr(4'h4, 32'h0000_0001);
        cmp(0, 0, 32'h0000_0001, 32'h0000_0002, 1'b1);
        $display("test enable done");
    endtask : t_enable

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        i_rstn = 1'b0;
        i_issue = '0;
        i_bus = '0;
        i_summary_overflow = 1'b0;
        cr = 32'h0000_0000;
        repeat (12) @(posedge i_mclk);
        t_reset();
        t_compare();
        t_width();
        t_clz();
        t_bits();
        t_enable();
        report_and_stop();
    end

    // Cuts a hang short well after the expected hundred or so cycles
    initial begin
        repeat (3000) @(posedge i_mclk);
        n_errors++;
        report_and_stop();
    end

endmodule : tb_top
